// ===== common/nco_evt_if.sv
`timescale 1ns/1ps
`default_nettype none

interface nco_evt_if;
  logic sample;
  logic filterEn;
  logic level;
  logic rise;
  modport filt (input sample, input filterEn, output level, output rise);
  modport core (output sample, output filterEn, input level, input rise);
endinterface : nco_evt_if

`default_nettype wire

// ===== common/nco_pkg.sv
`default_nettype none

package nco_pkg;

  typedef struct packed {
    logic [6:0] div;
  } nco_prescale_sel_s;

  typedef struct packed {
    logic [3:0] samples;
    logic held;
    logic level;
    logic levelPrev;
  } nco_filt_s;

  typedef struct packed {
    logic [7:0] control_first;
    logic [7:0] ctrlB;
    logic [7:0] control_third;
    logic [7:0] evCtrl;
    logic [7:0] irqEn;
    logic [7:0] ctrlAShadow;
    logic [7:0] ctrlCShadow;
    logic [7:0] ctrlDShadow;
    logic [2:0] irqFlags;
    logic [23:0] cnt;
    logic [23:0] cntShadow;
    logic [23:0] cntRead;
    logic [23:0] cmp;
    logic [23:0] cmpShadow;
    logic [7:1] busy;
    logic [1:0] wave;
    logic [2:0] evPulse;
    logic phase;
    logic [5:0] setPipe;
    logic wake;
    logic [7:0] rdData;
  } nco_state_s;

endpackage : nco_pkg

`default_nettype wire

// ===== common/nco_timer_consts.svh
`ifndef NCO_TIMER_CONSTS_SVH
`define NCO_TIMER_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define NCO_OFS_CONTROL_FIRST 5'h00
`define NCO_OFS_MODE_CONFIG 5'h01
`define NCO_OFS_CONTROL_THIRD 5'h02
`define NCO_OFS_CONTROL_FOURTH 5'h03
`define NCO_OFS_EVENT_CONTROL 5'h04
`define NCO_OFS_IRQ_ENABLES 5'h05
`define NCO_OFS_IRQ_FLAGS 5'h06
`define NCO_OFS_SYNC_STATUS 5'h07
`define NCO_OFS_COUNT0 5'h10
`define NCO_OFS_COUNT1 5'h11
`define NCO_OFS_COUNT2 5'h12
`define NCO_OFS_COMPARE0 5'h14
`define NCO_OFS_COMPARE1 5'h15
`define NCO_OFS_COMPARE2 5'h16

// ----------------------------------------
// Field positions
// ----------------------------------------
`define NCO_CF_ENABLE 0
`define NCO_CF_PRESCALE_SEL_LSB 1
`define NCO_CF_PRESCALE_SEL_MSB 3
`define NCO_CF_RUN_STDBY 7
`define NCO_MC_MODE_LSB 0
`define NCO_MC_MODE_MSB 2
`define NCO_MC_CH0_EVMODE 6
`define NCO_MC_CH1_EVMODE 7
`define NCO_CT_OUT_EN0 0
`define NCO_CT_OUT_EN1 1
`define NCO_CD_CMD_LSB 0
`define NCO_CD_CMD_MSB 1
`define NCO_EC_INPUT_EN 0
`define NCO_EC_ACTION_LSB 1
`define NCO_EC_ACTION_MSB 2
`define NCO_EC_FILTER_EN 3
`define NCO_ST_CTRL_FIRST 1
`define NCO_ST_CTRL_THIRD 2
`define NCO_ST_CTRL_FOURTH 3
`define NCO_ST_COUNT 4
`define NCO_ST_PERIOD 5
`define NCO_ST_COMPARE_LOW_BYTE 6
`define NCO_ST_COMPARE_HIGH_BYTE 7

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define NCO_MODE_FREQ 3'h0
`define NCO_MODE_PULSE 3'h1
`define NCO_MODE_HALF_DUTY 3'h2
`define NCO_MODE_PWM8 3'h7
`define NCO_CMD_UPDATE 2'h1
`define NCO_ACT_RESTART 2'h0
`define NCO_ACT_PAUSE 2'h1
`define NCO_REG_RESET 8'h00
`define NCO_IRQ_MASK 8'h07

`endif

// ===== src/nco_noise_filter.sv
`timescale 1ns/1ps
`default_nettype none

module nco_noise_filter
  import nco_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  nco_evt_if.filt ev
);
  nco_filt_s s;
  nco_filt_s n;

  always_comb
  begin
    n = s;
    n.samples = {s.samples[2:0], ev.sample};
    if (s.samples == 4'hF || s.samples == 4'h0)
      n.held = s.samples[3];
    n.level = ev.filterEn ? s.held : ev.sample;
    n.levelPrev = s.level;
  end

  assign ev.level = s.level;
  assign ev.rise = s.level && !s.levelPrev;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= n;
  end

  a_filter_delay: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (ev.filterEn && $rose(ev.sample)) ##1 (ev.filterEn && ev.sample) [*5] |=> s.level)
    else $error("filtered level late");
  c_filter_rise: cover property (@(posedge ref_clk) disable iff (sys_rst)
    ev.filterEn && ev.rise);
endmodule : nco_noise_filter

`default_nettype wire

// ===== src/nco_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module nco_prescaler
  import nco_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic tick
);
  nco_prescale_sel_s s;
  nco_prescale_sel_s n;
  logic [6:0] mask;

  // Divide by 2**sel: a tick once the masked divider bits are all ones
  always_comb
  begin
    n = s;
    mask = 7'((8'h01 << sel) - 8'h01);
    tick = run && ((s.div & mask) == mask);
    n.div = run ? (s.div + 7'h01) : 7'h00;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= n;
  end
endmodule : nco_prescaler

`default_nettype wire

// ===== src/nco_timer.sv
// How it works
// - Half-duty NCO mode accumulates like pulse mode, toggling output on every carry.
// - Half-duty mode raises compare-0 and compare-1 events on alternating carries.
// - PWM mode: count byte 0 counts, byte 1 is period, compare bytes duty.
// - PWM counter runs zero to period then restarts; output set at zero, cleared on match.
// - Compare zero holds output low; compare above period holds it high.
// - Period byte sets resolution; period lasts divisor times period plus one clock cycles.
// - Output enable bit drives the waveform onto its pin, overriding the port.
// - Enabled pin carries PWM or frequency waveform; disabled pin carries nothing.
// - Mode configuration is ignored while the timer is enabled.
// - Waveforms to event system and custom logic bypass the pin enables.
// - Input filter passes a level only after four equal samples.
// - Enabled filter adds five clock cycles before the event action.
// - Synchronised registers are independent; writes while busy are ignored.
// - Count and control transfer at once; compare waits for overflow or update.
// - Clock request stays high while any synchronised write is pending.
// - Flags appear three cycles after the timer event; wake-up comes one cycle after the event.
// - Readable count holds its old value while a count or period write is pending.
// - Event pulse of one cycle per overflow and match, or waveform level if selected.
// - The event input acts only when the count-event input enable is set.
// - Flags set on overflow and match; request while flag and enable both set.
// - Standby halts timer unless run-in-standby; power-down always halts.
// - Mode field: 0 frequency, 1 NCO pulse, 2 NCO half-duty; 3 to 6 reserved.
// - NCO modes add compare to accumulator every clock; carry is overflow.
`timescale 1ns/1ps
`default_nettype none
`include "nco_timer_consts.svh"

module nco_timer
  import nco_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [4:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic eventIn,
  input wire logic sleepStandby,
  input wire logic sleepPowerDown,
  output logic [1:0] waveOutPin,
  output logic [1:0] waveOutPinEn,
  output logic [1:0] waveToLogic,
  output logic eventOvf,
  output logic [1:0] eventCmp,
  output logic irqReq,
  output logic clockRequest,
  output logic wakeRequest
);
  nco_state_s s;
  nco_state_s n;
  nco_evt_if evBus ();
  logic tick;
  logic run;
  logic [2:0] mode;
  logic isPwm;
  logic paused;
  logic ovf;
  logic [1:0] match;
  logic cmpTake;
  logic cmpUpdate;
  logic [24:0] sum;
  logic [7:0] nextLow;
  logic [7:0] cmpByte;
  logic [2:0] flagClr;

  // ----------------------------------------
  // Run control and helpers
  // ----------------------------------------
  assign mode = s.ctrlB[`NCO_MC_MODE_MSB:`NCO_MC_MODE_LSB];
  assign isPwm = (mode == `NCO_MODE_PWM8);
  assign run = s.control_first[`NCO_CF_ENABLE] && !sleepPowerDown
    && !(sleepStandby && !s.control_first[`NCO_CF_RUN_STDBY]);
  assign paused = s.evCtrl[`NCO_EC_INPUT_EN] && evBus.level
    && (s.evCtrl[`NCO_EC_ACTION_MSB:`NCO_EC_ACTION_LSB] == `NCO_ACT_PAUSE);
  assign evBus.sample = eventIn;
  assign evBus.filterEn = s.evCtrl[`NCO_EC_FILTER_EN];

  nco_prescaler u_prescaler (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .run (run),
    .sel (s.control_first[`NCO_CF_PRESCALE_SEL_MSB:`NCO_CF_PRESCALE_SEL_LSB]),
    .tick (tick)
  );

  nco_noise_filter u_filter (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .ev (evBus)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    n = s;
    ovf = 1'b0;
    match = 2'b00;
    cmpUpdate = 1'b0;
    flagClr = 3'h0;
    cmpByte = 8'h00;
    nextLow = 8'h00;
    sum = {1'b0, s.cnt} + {1'b0, s.cmp};
    n.wake = 1'b0;
    n.rdData = 8'h00;

    // Timer core
    if (run && !paused)
    begin
      case (mode)
        `NCO_MODE_FREQ:
        begin
          if (tick)
          begin
            if (s.cnt >= s.cmp)
            begin
              n.cnt = 24'h00_0000;
              ovf = 1'b1;
              n.wave = {2{~s.wave[0]}};
              n.phase = ~s.phase;
              match = s.phase ? 2'b10 : 2'b01;
            end
            else
              n.cnt = s.cnt + 24'h00_0001;
          end
        end
        `NCO_MODE_PULSE:
        begin
          n.cnt = sum[23:0];
          ovf = sum[24];
          n.wave = {2{sum[24]}};
          match = {s.wave[0] && !sum[24], sum[24]};
        end
        `NCO_MODE_HALF_DUTY:
        begin
          n.cnt = sum[23:0];
          ovf = sum[24];
          if (sum[24])
          begin
            n.wave = {2{~s.wave[0]}};
            match = s.wave[0] ? 2'b10 : 2'b01;
          end
        end
        `NCO_MODE_PWM8:
        begin
          if (tick)
          begin
            // Low byte counts, second byte is the period
            if (s.cnt[7:0] >= s.cnt[15:8])
            begin
              nextLow = 8'h00;
              ovf = 1'b1;
            end
            else
              nextLow = s.cnt[7:0] + 8'h01;
            n.cnt[7:0] = nextLow;
            for (int i = 0; i < 2; i++)
            begin
              cmpByte = s.cmp[8 * i +: 8];
              if (cmpByte == 8'h00)
                n.wave[i] = 1'b0;
              else if (cmpByte > s.cnt[15:8])
                n.wave[i] = 1'b1;
              else
                n.wave[i] = (nextLow < cmpByte);
              match[i] = (nextLow == cmpByte);
            end
          end
        end
        default:
        begin
          n.cnt = s.cnt;
        end
      endcase
    end

    // Event action: restart
    if (run && s.evCtrl[`NCO_EC_INPUT_EN] && evBus.rise
      && (s.evCtrl[`NCO_EC_ACTION_MSB:`NCO_EC_ACTION_LSB] == `NCO_ACT_RESTART))
    begin
      if (isPwm)
        n.cnt[7:0] = 8'h00;
      else
        n.cnt = 24'h00_0000;
    end

    n.evPulse = {match, ovf};

    // Transfers of pending writes into the core
    if (s.busy[`NCO_ST_CTRL_FIRST])
    begin
      n.control_first = s.ctrlAShadow;
      n.busy[`NCO_ST_CTRL_FIRST] = 1'b0;
    end
    if (s.busy[`NCO_ST_CTRL_THIRD])
    begin
      n.control_third = s.ctrlCShadow;
      n.busy[`NCO_ST_CTRL_THIRD] = 1'b0;
    end
    if (s.busy[`NCO_ST_CTRL_FOURTH])
    begin
      cmpUpdate = (s.ctrlDShadow[`NCO_CD_CMD_MSB:`NCO_CD_CMD_LSB] == `NCO_CMD_UPDATE);
      n.busy[`NCO_ST_CTRL_FOURTH] = 1'b0;
    end
    if (s.busy[`NCO_ST_COUNT])
    begin
      if (isPwm)
        n.cnt[7:0] = s.cntShadow[7:0];
      else
        n.cnt = s.cntShadow;
      n.busy[`NCO_ST_COUNT] = 1'b0;
    end
    if (s.busy[`NCO_ST_PERIOD])
    begin
      n.cnt[15:8] = s.cntShadow[15:8];
      n.busy[`NCO_ST_PERIOD] = 1'b0;
    end
    if ((ovf || cmpUpdate) && s.busy[`NCO_ST_COMPARE_LOW_BYTE])
    begin
      if (isPwm)
        n.cmp[7:0] = s.cmpShadow[7:0];
      else
        n.cmp = s.cmpShadow;
      n.busy[`NCO_ST_COMPARE_LOW_BYTE] = 1'b0;
    end
    if ((ovf || cmpUpdate) && s.busy[`NCO_ST_COMPARE_HIGH_BYTE])
    begin
      n.cmp[15:8] = s.cmpShadow[15:8];
      n.busy[`NCO_ST_COMPARE_HIGH_BYTE] = 1'b0;
    end

    // Readable count follows the core when no count write is pending
    if (!s.busy[`NCO_ST_COUNT] && !s.busy[`NCO_ST_PERIOD])
      n.cntRead = s.cnt;

    // Register writes; a register still busy ignores the write
    if (regWr)
    begin
      case (regAddr)
        `NCO_OFS_CONTROL_FIRST:
          if (!s.busy[`NCO_ST_CTRL_FIRST])
          begin
            n.ctrlAShadow = regWrData;
            n.busy[`NCO_ST_CTRL_FIRST] = 1'b1;
          end
        `NCO_OFS_MODE_CONFIG:
          if (!s.control_first[`NCO_CF_ENABLE])
            n.ctrlB = regWrData;
        `NCO_OFS_CONTROL_THIRD:
          if (!s.busy[`NCO_ST_CTRL_THIRD])
          begin
            n.ctrlCShadow = regWrData;
            n.busy[`NCO_ST_CTRL_THIRD] = 1'b1;
          end
        `NCO_OFS_CONTROL_FOURTH:
          if (!s.busy[`NCO_ST_CTRL_FOURTH])
          begin
            n.ctrlDShadow = regWrData;
            n.busy[`NCO_ST_CTRL_FOURTH] = 1'b1;
          end
        `NCO_OFS_EVENT_CONTROL:
          if (!s.control_first[`NCO_CF_ENABLE])
            n.evCtrl = regWrData;
        `NCO_OFS_IRQ_ENABLES: n.irqEn = regWrData & `NCO_IRQ_MASK;
        `NCO_OFS_IRQ_FLAGS: flagClr = regWrData[2:0];
        `NCO_OFS_COUNT0:
          if (!s.busy[`NCO_ST_COUNT])
          begin
            n.cntShadow[7:0] = regWrData;
            n.busy[`NCO_ST_COUNT] = isPwm;
          end
        `NCO_OFS_COUNT1:
          if (!s.busy[`NCO_ST_PERIOD])
          begin
            n.cntShadow[15:8] = regWrData;
            n.busy[`NCO_ST_PERIOD] = isPwm;
          end
        `NCO_OFS_COUNT2:
          if (!s.busy[`NCO_ST_COUNT])
          begin
            n.cntShadow[23:16] = regWrData;
            n.busy[`NCO_ST_COUNT] = !isPwm;
          end
        `NCO_OFS_COMPARE0:
          if (!s.busy[`NCO_ST_COMPARE_LOW_BYTE])
          begin
            n.cmpShadow[7:0] = regWrData;
            n.busy[`NCO_ST_COMPARE_LOW_BYTE] = isPwm;
          end
        `NCO_OFS_COMPARE1:
          if (!s.busy[`NCO_ST_COMPARE_HIGH_BYTE])
          begin
            n.cmpShadow[15:8] = regWrData;
            n.busy[`NCO_ST_COMPARE_HIGH_BYTE] = isPwm;
          end
        `NCO_OFS_COMPARE2:
          if (!s.busy[`NCO_ST_COMPARE_LOW_BYTE])
          begin
            n.cmpShadow[23:16] = regWrData;
            n.busy[`NCO_ST_COMPARE_LOW_BYTE] = !isPwm;
          end
        default:
        begin
          n.rdData = 8'h00;
        end
      endcase
    end

    // Flag synchronisation: a set arriving with a clear wins
    n.setPipe = {s.setPipe[2:0], s.evPulse};
    n.irqFlags = (s.irqFlags & ~flagClr) | s.setPipe[5:3];
    n.wake = sleepStandby && |(s.evPulse & s.irqEn[2:0]);

    // Register reads, data valid in the following cycle only
    if (regRd)
    begin
      case (regAddr)
        `NCO_OFS_CONTROL_FIRST: n.rdData = s.control_first;
        `NCO_OFS_MODE_CONFIG: n.rdData = s.ctrlB;
        `NCO_OFS_CONTROL_THIRD: n.rdData = s.control_third;
        `NCO_OFS_CONTROL_FOURTH: n.rdData = s.ctrlDShadow;
        `NCO_OFS_EVENT_CONTROL: n.rdData = s.evCtrl;
        `NCO_OFS_IRQ_ENABLES: n.rdData = s.irqEn;
        `NCO_OFS_IRQ_FLAGS: n.rdData = {5'h00, s.irqFlags};
        `NCO_OFS_SYNC_STATUS: n.rdData = {s.busy, 1'b0};
        `NCO_OFS_COUNT0: n.rdData = s.cntRead[7:0];
        `NCO_OFS_COUNT1: n.rdData = s.cntRead[15:8];
        `NCO_OFS_COUNT2: n.rdData = s.cntRead[23:16];
        `NCO_OFS_COMPARE0: n.rdData = s.cmp[7:0];
        `NCO_OFS_COMPARE1: n.rdData = s.cmp[15:8];
        `NCO_OFS_COMPARE2: n.rdData = s.cmp[23:16];
        default: n.rdData = 8'h00;
      endcase
    end
  end

  // Compare shadows move at overflow or on the update command
  assign cmpTake = ovf || cmpUpdate;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      s <= '0;
    else
      s <= n;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign regRdData = s.rdData;
  assign waveOutPinEn = s.control_third[`NCO_CT_OUT_EN1:`NCO_CT_OUT_EN0];
  assign waveOutPin = s.wave & s.control_third[`NCO_CT_OUT_EN1:`NCO_CT_OUT_EN0];
  assign waveToLogic = s.wave;
  assign eventOvf = s.evPulse[0];
  assign eventCmp[0] = s.ctrlB[`NCO_MC_CH0_EVMODE] ? s.wave[0] : s.evPulse[1];
  assign eventCmp[1] = s.ctrlB[`NCO_MC_CH1_EVMODE] ? s.wave[1] : s.evPulse[2];
  assign irqReq = |(s.irqFlags & s.irqEn[2:0]);
  assign clockRequest = run || (|s.busy);
  assign wakeRequest = s.wake;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  a_busy_write_block: assert property (
    regWr && regAddr == `NCO_OFS_CONTROL_FIRST && s.busy[`NCO_ST_CTRL_FIRST]
    |=> $stable(s.ctrlAShadow))
    else $error("write accepted while busy");
  a_ctrl_transfer: assert property (
    regWr && regAddr == `NCO_OFS_CONTROL_FIRST && !s.busy[`NCO_ST_CTRL_FIRST]
    |=> s.busy[`NCO_ST_CTRL_FIRST] ##1 (!s.busy[`NCO_ST_CTRL_FIRST]
    && s.control_first == $past(s.ctrlAShadow)))
    else $error("control transfer not immediate");
  a_cmp_wait_ovf: assert property (
    s.busy[`NCO_ST_COMPARE_LOW_BYTE] && !cmpTake |=> s.busy[`NCO_ST_COMPARE_LOW_BYTE])
    else $error("compare moved without overflow");
  a_pwm_zero_low: assert property (
    isPwm && run && !paused && tick && s.cmp[7:0] == 8'h00 |=> !s.wave[0])
    else $error("zero compare not low");
  a_pwm_over_high: assert property (
    isPwm && run && !paused && tick && s.cmp[15:8] > s.cnt[15:8] |=> s.wave[1])
    else $error("compare above period not high");
  a_half_duty_toggle: assert property (
    mode == `NCO_MODE_HALF_DUTY && run && !paused && sum[24]
    |=> s.wave[0] != $past(s.wave[0]) && s.evPulse[0])
    else $error("no toggle on carry");
  a_flag_delay: assert property (
    s.evPulse[0] |-> ##3 s.irqFlags[0])
    else $error("flag not set three cycles after event");
  a_irq_level: assert property (
    s.irqFlags[0] && s.irqEn[0] && !regWr |=> irqReq)
    else $error("request dropped without clear");
  a_mode_protect: assert property (
    s.control_first[`NCO_CF_ENABLE] |=> $stable(s.ctrlB))
    else $error("mode changed while enabled");
  a_standby_halt: assert property (
    sleepStandby && !s.control_first[`NCO_CF_RUN_STDBY] && !s.busy[`NCO_ST_COUNT]
    && !s.busy[`NCO_ST_PERIOD] |=> $stable(s.cnt))
    else $error("timer ran in standby");
  a_clock_hold: assert property (
    |s.busy |-> clockRequest)
    else $error("clock request dropped while busy");
  a_pin_gate: assert property (
    !s.control_third[`NCO_CT_OUT_EN0] |-> !waveOutPin[0] && !waveOutPinEn[0])
    else $error("pin driven while disabled");

  c_half_duty_compare_high_byte: cover property (mode == `NCO_MODE_HALF_DUTY && s.evPulse[2]);
  c_pwm_wrap: cover property (isPwm && s.evPulse[0]);
  c_cmp_update: cover property (cmpUpdate && s.busy[`NCO_ST_COMPARE_LOW_BYTE]);
  c_irq_wake: cover property (irqReq && wakeRequest);
endmodule : nco_timer

`default_nettype wire

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "nco_timer_consts.svh"

module testbench
  import nco_pkg::*;
;
  logic ref_clk;
  logic sys_rst;
  logic [4:0] regAddr;
  logic [7:0] regWrData;
  logic regWr;
  logic regRd;
  logic [7:0] regRdData;
  logic eventIn;
  logic sleepStandby;
  logic sleepPowerDown;
  logic [1:0] waveOutPin;
  logic [1:0] waveOutPinEn;
  logic [1:0] waveToLogic;
  logic eventOvf;
  logic [1:0] eventCmp;
  logic irqReq;
  logic clockRequest;
  logic wakeRequest;
  logic [7:0] d;
  int err_count;
  int n_tests;
  int nOvf;
  int nC0;
  int nC1;
  int nTog;
  int nHi;
  int nWake;

  nco_timer dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .eventIn(eventIn),
    .sleepStandby(sleepStandby), .sleepPowerDown(sleepPowerDown), .waveOutPin(waveOutPin),
    .waveOutPinEn(waveOutPinEn), .waveToLogic(waveToLogic), .eventOvf(eventOvf),
    .eventCmp(eventCmp), .irqReq(irqReq), .clockRequest(clockRequest),
    .wakeRequest(wakeRequest)
  );

  always #25 ref_clk = ~ref_clk;

  // ----------------------------------------
  // Bus and checking tasks
  // ----------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
      err_count++;
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    v = regRdData;
  endtask : rd

  // Polls status until every transfer has landed
  task automatic waitIdle;
    int i;
    logic [7:0] s;
    i = 0;
    s = 8'hff;
    while (s !== 8'h00 && i < 50)
    begin
      rd(`NCO_OFS_SYNC_STATUS, s);
      i++;
    end
    if (s !== 8'h00)
    begin
      $display("wrong value status expected 0 seen %0h", s);
      err_count++;
      results();
    end
  endtask : waitIdle

  // Counts event pulses, waveform toggles and pin high cycles
  task automatic run(input int n);
    logic prev;
    nOvf = 0;
    nC0 = 0;
    nC1 = 0;
    nTog = 0;
    nHi = 0;
    nWake = 0;
    prev = waveToLogic[0];
    repeat (n)
    begin
      @(posedge ref_clk);
      #1;
      nOvf += int'(eventOvf);
      nC0 += int'(eventCmp[0]);
      nC1 += int'(eventCmp[1]);
      nTog += int'(waveToLogic[0] != prev);
      prev = waveToLogic[0];
      nHi += int'(waveOutPin[0]);
      nWake += int'(wakeRequest);
    end
  endtask : run

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    regAddr = 5'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    eventIn = 1'b0;
    sleepStandby = 1'b0;
    sleepPowerDown = 1'b0;
    err_count = 0;
    n_tests = 0;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(`NCO_OFS_CONTROL_FIRST, d);
    chk("control_first", 8'h00, d);
    wr(5'h08, 8'hff);
    rd(5'h08, d);
    chk("unmapped", 8'h00, d);
    $display("reset test done");
    // PWM: period 3, duty 2 on channel 0, channel 1 above period
    wr(`NCO_OFS_MODE_CONFIG, 8'h07);
    wr(`NCO_OFS_COUNT1, 8'h03);
    wr(`NCO_OFS_COMPARE0, 8'h02);
    wr(`NCO_OFS_COMPARE1, 8'h05);
    wr(`NCO_OFS_CONTROL_FOURTH, 8'h01);
    waitIdle();
    wr(`NCO_OFS_CONTROL_THIRD, 8'h03);
    wr(`NCO_OFS_CONTROL_FIRST, 8'h01);
    waitIdle();
    run(40);
    chk("pwm ovf", 8'h0a, 8'(nOvf));
    chk("pwm compare_low_byte ev", 8'h0a, 8'(nC0));
    chk("pwm high", 8'h14, 8'(nHi));
    chk("pin en", 8'h03, 8'(waveOutPinEn));
    chk("pin1", 8'h01, 8'(waveOutPin[1]));
    wr(`NCO_OFS_MODE_CONFIG, 8'h02);
    rd(`NCO_OFS_MODE_CONFIG, d);
    chk("mode locked", 8'h07, d);
    wr(`NCO_OFS_COMPARE0, 8'h00);
    waitIdle();
    run(40);
    chk("pwm zero", 8'h00, 8'(nHi));
    wr(`NCO_OFS_IRQ_ENABLES, 8'h01);
    run(10);
    chk("irq set", 8'h01, 8'(irqReq));
    wr(`NCO_OFS_CONTROL_THIRD, 8'h00);
    waitIdle();
    run(2);
    chk("pin off", 8'h00, 8'({waveOutPinEn, waveOutPin}));
    chk("logic wave", 8'h01, 8'(waveToLogic[1]));
    wr(`NCO_OFS_CONTROL_FIRST, 8'h00);
    waitIdle();
    run(6);
    wr(`NCO_OFS_IRQ_FLAGS, 8'h07);
    run(2);
    chk("irq clear", 8'h00, 8'(irqReq));
    $display("pwm test done");
    // Half-duty NCO with increment of half the accumulator range
    wr(`NCO_OFS_MODE_CONFIG, 8'h02);
    wr(`NCO_OFS_EVENT_CONTROL, 8'h03);
    wr(`NCO_OFS_COMPARE0, 8'h00);
    wr(`NCO_OFS_COMPARE1, 8'h00);
    wr(`NCO_OFS_COMPARE2, 8'h80);
    wr(`NCO_OFS_CONTROL_FOURTH, 8'h01);
    waitIdle();
    wr(`NCO_OFS_CONTROL_FIRST, 8'h01);
    waitIdle();
    run(40);
    chk("nco ovf", 8'h14, 8'(nOvf));
    chk("nco toggles", 8'h14, 8'(nTog));
    chk("nco compare_low_byte", 8'h0a, 8'(nC0));
    chk("nco compare_high_byte", 8'h0a, 8'(nC1));
    chk("nco pin", 8'h00, 8'(nHi));
    @(posedge ref_clk);
    sleepPowerDown <= 1'b1;
    run(4);
    run(20);
    chk("power down", 8'h00, 8'(nOvf));
    @(posedge ref_clk);
    sleepPowerDown <= 1'b0;
    sleepStandby <= 1'b1;
    run(4);
    run(20);
    chk("standby halt", 8'h00, 8'(nOvf + nWake));
    chk("clock idle", 8'h00, 8'(clockRequest));
    wr(`NCO_OFS_CONTROL_FIRST, 8'h81);
    #1;
    chk("clock hold", 8'h01, 8'(clockRequest));
    waitIdle();
    run(20);
    chk("run standby", 8'h0a, 8'(nOvf));
    chk("wake", 8'h0a, 8'(nWake));
    @(posedge ref_clk);
    sleepStandby <= 1'b0;
    eventIn <= 1'b1;
    run(4);
    run(20);
    chk("paused", 8'h00, 8'(nOvf));
    @(posedge ref_clk);
    eventIn <= 1'b0;
    run(4);
    run(20);
    chk("resumed", 8'h0a, 8'(nOvf));
    $display("nco test done");
    // Frequency mode, compare 1, divide by 2, channel 0 event as level
    wr(`NCO_OFS_CONTROL_FIRST, 8'h00);
    waitIdle();
    wr(`NCO_OFS_IRQ_ENABLES, 8'h00);
    wr(`NCO_OFS_MODE_CONFIG, 8'h40);
    wr(`NCO_OFS_EVENT_CONTROL, 8'h09);
    wr(`NCO_OFS_COMPARE0, 8'h01);
    wr(`NCO_OFS_COMPARE2, 8'h00);
    wr(`NCO_OFS_CONTROL_FOURTH, 8'h01);
    waitIdle();
    wr(`NCO_OFS_IRQ_FLAGS, 8'h07);
    wr(`NCO_OFS_CONTROL_FIRST, 8'h03);
    waitIdle();
    run(40);
    chk("freq ovf", 8'h0a, 8'(nOvf));
    chk("freq toggles", 8'h0a, 8'(nTog));
    chk("ev level", 8'h14, 8'(nC0));
    chk("freq compare_high_byte", 8'h05, 8'(nC1));
    // Filtered restart: count reads 3 four cycles after the late edge
    wr(`NCO_OFS_COMPARE0, 8'hff);
    wr(`NCO_OFS_COMPARE2, 8'h00);
    wr(`NCO_OFS_CONTROL_FIRST, 8'h01);
    waitIdle();
    @(posedge ref_clk);
    eventIn <= 1'b1;
    run(10);
    rd(`NCO_OFS_COUNT0, d);
    chk("filtered restart", 8'h03, d);
    @(posedge ref_clk);
    eventIn <= 1'b0;
    $display("freq test done");
    // Pulse mode with half-range increment
    wr(`NCO_OFS_CONTROL_FIRST, 8'h00);
    waitIdle();
    wr(`NCO_OFS_MODE_CONFIG, 8'h01);
    wr(`NCO_OFS_COMPARE0, 8'h00);
    wr(`NCO_OFS_COMPARE2, 8'h80);
    wr(`NCO_OFS_CONTROL_FOURTH, 8'h01);
    waitIdle();
    wr(`NCO_OFS_CONTROL_FIRST, 8'h01);
    waitIdle();
    run(20);
    chk("pulse ovf", 8'h0a, 8'(nOvf));
    chk("pulse start", 8'h0a, 8'(nC0));
    chk("pulse end", 8'h0a, 8'(nC1));
    chk("pulse toggles", 8'h14, 8'(nTog));
    $display("pulse test done");
    results();
  end
endmodule : testbench

`default_nettype wire
